// *** rtl/tx_alarm_pkg.sv ***
// tx_alarm_pkg: register offsets, field positions, reset values and
// detection constants for the transmit alarm and signal-loss block.
// assumes a byte-wide register port inside the device, one clock domain.
package tx_alarm_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] ADDR_ALARM_SUMMARY = 8'h89;
  localparam logic [7:0] ADDR_ABSENT_CONTROL = 8'h8a;
  localparam logic [7:0] ADDR_ABSENT_STATE = 8'h8b;

  // alarm summary field positions
  localparam int SUM_REFCLK = 6;
  localparam int SUM_ABSENT = 5;
  localparam int SUM_LOCK = 4;
  localparam int SUM_BUFFER = 3;
  localparam int SUM_PAT_ERR = 2;
  localparam int SUM_PAT_SYNC = 1;
  localparam int SUM_QUALITY = 0;

  // signal-absent control field positions and reset value
  localparam int CTL_QUALITY_EN = 3;
  localparam int CTL_MODE_LSB = 1;
  localparam logic [7:0] CTL_RESET = 8'h0e;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h0e;

  // signal-absent state field positions and reset value
  localparam int ST_QUALITY = 4;
  localparam int ST_POLARITY = 3;
  localparam int ST_RUN = 2;
  localparam int ST_ABSENT = 0;
  localparam logic [7:0] ST_RESET = 8'h00;

  // run-length detection modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ZEROS = 2'h1;

  // run-length arithmetic: assert = (limit*5+2)*1024 bits,
  // clear = limit*16+1 good fields of 1024 bits
  localparam int RUN_ASSERT_MUL = 5;
  localparam int RUN_ASSERT_ADD = 2;
  localparam int FIELD_BITS = 1024;
  localparam int RUN_CLEAR_MUL = 16;
  localparam int RUN_CLEAR_ADD = 1;
  localparam int RUN_CNT_W = 21;
  localparam int FIELD_CNT_W = 10;
  localparam int GOOD_CNT_W = 12;

  // quality release default value of the external limit register
  localparam logic [5:0] QUALITY_RELEASE_DEFAULT = 6'h08;

  // cycles the buffer error stays visible before auto recovery clears it
  localparam int BUFFER_RECOVER_CYCLES = 16;

endpackage

// *** rtl/tx_alarm_signal_loss_status.sv ***
// tx_alarm_signal_loss_status: transmit alarm summary, signal-absent
// control and signal-absent state registers with their detectors.
// assumes analogue status levels arrive asynchronously, while the
// sampled data stream, counters and limit registers share mclk.
//
// Summary of operation
// - bit 6 shows reference clock missing
// - bit 5 shows overall signal loss
// - bit 4 shows transmit loop unlocked
// - bit 3 flags buffer overflow or underflow
// - auto recover clears buffer error flag itself
// - bit 2 set when error count reaches limit
// - bit 1 zero while checker disabled
// - enabled checker losing alignment sets bit 1
// - bit 0 set when quality meets threshold
// - control bit 3 routes quality alarm to loss
// - mode 00 off, 01 zeros, 1x both
// - control register resets to 0000 1110
// - state bit 4 high when quality below limits
// - lock loss forces quality state bit low
// - state bit 3 holds last run polarity
// - state bit 2 shows run detection state
// - state bit 0 overall loss, resets zero
// - assert after (limit*5+2)*1024 identical bits
// - clear after limit*16+1 good 1024-bit fields
// - quality alarm releases at release limit
`timescale 1ns/10ps

module tx_alarm_signal_loss_status
  import tx_alarm_pkg::*;
#(
  parameter int RECOVER_CYCLES = BUFFER_RECOVER_CYCLES // buffer error hold
)
(
  input wire logic mclk, // 20 MHz device clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read data, registered
  output logic reg_rd_valid, // read data valid pulse
  input wire logic refclk_coarse_dev, // async: refclk far off frequency
  input wire logic tx_input_lost, // async: analogue input loss
  input wire logic pll_unlocked, // async: transmit loop lost lock
  input wire logic pattern_sync_lost, // async: checker out of alignment
  input wire logic buffer_overflow, // elastic buffer overflow pulse
  input wire logic buffer_underflow, // elastic buffer underflow pulse
  input wire logic buffer_auto_recover, // auto recovery enable level
  input wire logic buffer_reset, // manual buffer reset level
  input wire logic pattern_checker_en, // pattern checker enabled
  input wire logic [7:0] pattern_error_count, // checker error count
  input wire logic [7:0] pattern_error_limit, // programmed error limit
  input wire logic [5:0] quality_measure, // eye opening measurement
  input wire logic [5:0] quality_assert_limit, // quality assert limit
  input wire logic [5:0] quality_release_limit, // quality release limit
  input wire logic [7:0] run_assert_limit, // run length assert limit
  input wire logic [7:0] run_clear_limit, // run length clear limit
  input wire logic data_bit, // sampled transmit data bit
  input wire logic data_strobe, // data_bit is valid this cycle
  output logic signal_absent_flag // overall signal loss, registered
);

  // ---------------- async input synchronisers ----------------
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] async_in; // raw asynchronous levels
  logic [NSYNC-1:0] sync_meta; // first stage, read only by second
  logic [NSYNC-1:0] sync_out; // second stage, safe to use

  assign async_in = {pattern_sync_lost, pll_unlocked, tx_input_lost,
                     refclk_coarse_dev};

  // two flops per level; nothing but the second flop reads the first
  // only levels that stand for a few cycles are seen; short glitches
  // on these pins may be lost, which suits slow analogue detectors
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          sync_meta[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end
        else
        begin
          sync_meta[gi] <= async_in[gi];
          sync_out[gi] <= sync_meta[gi];
        end
      end
    end
  endgenerate

  wire refclk_missing_flag = sync_out[0];
  wire input_lost_s = sync_out[1]; // analogue loss, synced
  wire lock_lost_flag = sync_out[2];
  wire sync_lost_s = sync_out[3]; // checker alignment loss, synced

  // ---------------- control register ----------------
  logic [7:0] ctl; // signal-absent control, bits 3:1 writable
  wire quality_absent_enable = ctl[CTL_QUALITY_EN];
  wire [1:0] run_length_detect_mode = ctl[CTL_MODE_LSB +: 2];

  // mode and enable decode straight from the stored control bits
  // decode helper, used by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  wire ctl_wr = reg_wr & hit(reg_addr, ADDR_ABSENT_CONTROL);

  // reserved bits masked so they always read zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ctl <= CTL_RESET;
    else if (ctl_wr)
      ctl <= reg_wdata & CTL_WRITE_MASK;
  end

  // ---------------- buffer error flag ----------------
  logic buffer_error_flag; // sticky overflow/underflow alarm
  logic [7:0] recover_cnt; // cycles since the last buffer event
  // the hold counter restarts on every event, so a burst keeps it up
  wire buffer_event = buffer_overflow | buffer_underflow;
  wire recover_done = buffer_auto_recover &&
                      (recover_cnt >= 8'(RECOVER_CYCLES - 1));
  // a new event wins over any clear in the same cycle
  wire next_buffer_error = buffer_event |
                           (buffer_error_flag & ~buffer_reset &
                            ~recover_done);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      buffer_error_flag <= 1'b0;
      recover_cnt <= 8'h00;
    end
    else
    begin
      buffer_error_flag <= next_buffer_error;
      if (buffer_event || !buffer_error_flag)
        recover_cnt <= 8'h00;
      else if (!recover_done)
        recover_cnt <= recover_cnt + 8'h01;
    end
  end

  // ---------------- pattern checker alarms ----------------
  // live comparisons; a zero limit means the alarm is up at once
  wire pattern_error_limit_flag =
    pattern_error_count >= pattern_error_limit;
  wire pattern_sync_lost_flag =
    pattern_checker_en & sync_lost_s;

  // ---------------- quality alarm with hysteresis ----------------
  // limits come from outside registers and are used as plain levels
  logic quality_alarm_flag; // eye too small
  wire quality_hit = quality_measure <= quality_assert_limit;
  wire quality_release = quality_measure >= quality_release_limit;
  wire next_quality_alarm = quality_hit |
                            (quality_alarm_flag & ~quality_release);

  // gap between the two limits keeps the alarm from chattering
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      quality_alarm_flag <= 1'b0;
    else
      quality_alarm_flag <= next_quality_alarm;
  end

  wire quality_below = (quality_measure < quality_assert_limit) &&
                       (quality_measure < quality_release_limit);
  wire quality_absent_state =
    quality_below & ~lock_lost_flag;

  // ---------------- run-length detector ----------------
  logic run_length_absent_state; // digital loss active
  logic run_polarity_last; // polarity of the triggering run
  logic prev_bit; // previous data bit
  logic [RUN_CNT_W-1:0] run_cnt; // length of current identical run
  logic [FIELD_CNT_W-1:0] field_cnt; // bit position in 1024-bit field
  logic field_toggle; // transition seen in the current field
  logic [GOOD_CNT_W-1:0] good_cnt; // consecutive good fields

  wire [RUN_CNT_W-1:0] run_target =
    RUN_CNT_W'(({13'h0000, run_assert_limit} * 21'(RUN_ASSERT_MUL) +
                21'(RUN_ASSERT_ADD)) * 21'(FIELD_BITS));
  wire [GOOD_CNT_W-1:0] good_target =
    GOOD_CNT_W'({4'h0, run_clear_limit} * 12'(RUN_CLEAR_MUL) +
                12'(RUN_CLEAR_ADD));

  wire same_bit = (data_bit == prev_bit);
  // the run counter saturates so a very long run cannot wrap short
  wire [RUN_CNT_W-1:0] next_run_cnt =
    !same_bit ? RUN_CNT_W'(1) :
    (run_cnt == {RUN_CNT_W{1'b1}}) ? run_cnt : run_cnt + RUN_CNT_W'(1);
  // zeros-only mode ignores runs of ones
  wire run_qualifies = (run_length_detect_mode != MODE_OFF) &&
                       ((run_length_detect_mode != MODE_ZEROS) ||
                        !data_bit);
  wire run_fire = data_strobe & run_qualifies &
                  (next_run_cnt >= run_target);
  // fields free-run from reset; they are not aligned to any run
  wire field_end = data_strobe &&
                   (field_cnt == FIELD_CNT_W'(FIELD_BITS - 1));
  wire field_good = field_toggle | (data_strobe & ~same_bit);
  wire [GOOD_CNT_W-1:0] next_good_cnt =
    !field_good ? '0 :
    (good_cnt == {GOOD_CNT_W{1'b1}}) ? good_cnt :
    good_cnt + GOOD_CNT_W'(1);
  wire run_clear = field_end & field_good & (next_good_cnt >= good_target);

  // bit counters only move on strobes so idle cycles do not count
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      prev_bit <= 1'b0;
      run_cnt <= '0;
      field_cnt <= '0;
      field_toggle <= 1'b0;
      good_cnt <= '0;
    end
    else if (data_strobe)
    begin
      prev_bit <= data_bit;
      run_cnt <= next_run_cnt;
      // wraps at the field length, which is a power of two
      field_cnt <= field_cnt + FIELD_CNT_W'(1);
      field_toggle <= field_end ? 1'b0 : field_good;
      if (field_end)
        good_cnt <= next_good_cnt;
    end
  end

  // detection state; a fresh trigger wins over a clear
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      run_length_absent_state <= 1'b0;
      run_polarity_last <= 1'b0;
    end
    else if (run_length_detect_mode == MODE_OFF)
      run_length_absent_state <= 1'b0;
    else if (run_fire)
    begin
      run_length_absent_state <= 1'b1;
      run_polarity_last <= data_bit;
    end
    else if (run_clear)
      run_length_absent_state <= 1'b0;
  end

  // ---------------- overall signal loss ----------------
  // three sources share one flag; run length and quality keep their own status bits,
  // but input loss has no bit of its own apart from the shared flag
  wire next_absent = input_lost_s | run_length_absent_state |
                     (quality_absent_enable &
                      quality_alarm_flag);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      signal_absent_flag <= 1'b0;
    else
      signal_absent_flag <= next_absent;
  end

  // ---------------- read path ----------------
  wire [7:0] summary_word = {1'b0, refclk_missing_flag, signal_absent_flag,
                             lock_lost_flag, buffer_error_flag,
                             pattern_error_limit_flag,
                             pattern_sync_lost_flag, quality_alarm_flag};
  wire [7:0] state_word = {3'h0, quality_absent_state, run_polarity_last,
                           run_length_absent_state, 1'b0,
                           signal_absent_flag};
  // unmapped addresses read zero
  wire [7:0] read_mux =
    hit(reg_addr, ADDR_ALARM_SUMMARY) ? summary_word :
    hit(reg_addr, ADDR_ABSENT_CONTROL) ? ctl :
    hit(reg_addr, ADDR_ABSENT_STATE) ? state_word : 8'h00;

  // the word is captured once per strobe, so software sees a coherent
  // snapshot of every bit taken at the same edge
  // reads only sample; no flag changes on a read
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd;
      if (reg_rd)
        reg_rdata <= read_mux;
    end
  end

endmodule

// *** test/tx_alarm_signal_loss_status_asserts.sv ***
// checker for the transmit alarm and signal-absent register block.
// assumes it is bound to the block and sees only its ports.
`timescale 1ns/10ps
module tx_alarm_signal_loss_status_asserts
  import tx_alarm_pkg::*;
(
  input wire logic mclk, // device clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rd_valid, // read data valid
  input wire logic tx_input_lost, // input loss level
  input wire logic pll_unlocked, // loop unlock level
  input wire logic pattern_checker_en, // checker enable
  input wire logic signal_absent_flag // overall loss
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // reads decoded per register
  wire rd_ctl = reg_rd && reg_addr == ADDR_ABSENT_CONTROL;
  wire rd_sum = reg_rd && reg_addr == ADDR_ALARM_SUMMARY;
  wire rd_st = reg_rd && reg_addr == ADDR_ABSENT_STATE;
  wire rd_none = reg_rd && !rd_ctl && !rd_sum && !rd_st;
  // long enough for the two-flop sync and the flag register
  sequence input_gone;
    tx_input_lost [*5];
  endsequence
  sequence checker_off;
    !pattern_checker_en [*4] ##0 rd_sum;
  endsequence
  sequence lock_gone;
    pll_unlocked [*4] ##0 rd_st;
  endsequence
  rd_answer_a: assert property (reg_rd |=> reg_rd_valid)
    else $error("read not answered next cycle");
  rd_quiet_a: assert property (!reg_rd |=> !reg_rd_valid)
    else $error("read valid without a read");
  data_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  ctl_spare_a: assert property (rd_ctl |=> reg_rdata[7:4] == 4'h0
    && !reg_rdata[0]) else $error("control spare bits not zero");
  st_spare_a: assert property (rd_st |=> reg_rdata[7:5] == 3'h0
    && !reg_rdata[1]) else $error("state spare bits not zero");
  unmapped_zero_a: assert property (rd_none |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  input_loss_a: assert property (input_gone |-> signal_absent_flag)
    else $error("input loss did not raise absent flag");
  checker_off_a: assert property (checker_off |=> !reg_rdata[1])
    else $error("sync flag set with checker off");
  lock_quality_a: assert property (lock_gone |=> !reg_rdata[4])
    else $error("quality state set during lock loss");
endmodule
bind tx_alarm_signal_loss_status tx_alarm_signal_loss_status_asserts i_chk (.*);

// *** test/tx_alarm_signal_loss_status_bench.sv ***
// bench for the transmit alarm and signal-absent register block.
// assumes the design package and the checker are compiled first.
`timescale 1ns/10ps
module tx_alarm_signal_loss_status_bench;
  import tx_alarm_pkg::*;
  logic mclk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic refclk_coarse_dev = 1'h0, tx_input_lost = 1'h0, pol = 1'h0;
  logic pll_unlocked = 1'h0, pattern_sync_lost = 1'h0;
  logic buffer_overflow = 1'h0, buffer_underflow = 1'h0;
  logic buffer_auto_recover = 1'h0, buffer_reset = 1'h0;
  logic pattern_checker_en = 1'h0, data_bit = 1'h0, data_strobe = 1'h0;
  logic [7:0] pattern_error_count = 8'h00, pattern_error_limit = 8'h05;
  logic [5:0] quality_measure = 6'h3f, quality_assert_limit = 6'h01;
  logic [5:0] quality_release_limit = 6'h08;
  logic [7:0] run_assert_limit = 8'h00, run_clear_limit = 8'h00;
  logic reg_rd_valid, signal_absent_flag;
  int error_cnt = 0, n_compared = 0;
  // short hold so auto recovery is seen within a few reads
  tx_alarm_signal_loss_status #(.RECOVER_CYCLES(6)) i_dut (.*);
  always #25 mclk = ~mclk;
  // inputs move 1 ns after the rising edge
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // spare cycle at the end keeps strobes from touching
  task automatic rd(logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'h1;
    tick;
    reg_rd = 1'h0;
    chk("rd_valid", {7'h0, reg_rd_valid}, 8'h01);
    d = reg_rdata;
    tick;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'h1;
    tick;
    reg_wr = 1'h0;
    tick;
  endtask
  // bounded wait; running out ends the run
  task automatic wait_flag(logic e);
    for (int i = 0; i < 10; i++)
    begin
      if (signal_absent_flag === e)
        return;
      tick;
    end
    chk("absent_flag", {7'h0, signal_absent_flag}, {7'h0, e});
    results;
  endtask
  // n strobes of b, alternating when alt is set
  task automatic send(logic b, int n, logic alt);
    data_strobe = 1'h1;
    for (int i = 0; i < n; i++)
    begin
      data_bit = b ^ (alt & i[0]);
      tick;
    end
    data_strobe = 1'h0;
  endtask
  task automatic t_reset;
    rd(ADDR_ABSENT_CONTROL);
    chk("ctl_rst", d, 8'h0e);
    rd(ADDR_ABSENT_STATE);
    chk("st_rst", d, 8'h00);
    rd(8'h8c);
    chk("unmapped", d, 8'h00);
    wr(ADDR_ABSENT_CONTROL, 8'hff);
    wr(ADDR_ALARM_SUMMARY, 8'hff);
    rd(ADDR_ABSENT_CONTROL);
    chk("ctl_mask", d, 8'h0e);
    rd(ADDR_ALARM_SUMMARY);
    chk("sum_ro", d, 8'h00);
  endtask
  // one live condition at a time, then checker disabled
  task automatic t_alarms;
    pattern_checker_en = 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      {refclk_coarse_dev, tx_input_lost, pll_unlocked,
        pattern_sync_lost} = 4'h8 >> i;
      repeat (3) tick;
      rd(ADDR_ALARM_SUMMARY);
      chk("alarm", d, (i == 3) ? 8'h02 : 8'h40 >> i);
    end
    pattern_checker_en = 1'h0;
    repeat (3) tick;
    rd(ADDR_ALARM_SUMMARY);
    chk("sync_off", d, 8'h00);
    pattern_sync_lost = 1'h0;
    pattern_error_count = 8'h05;
    rd(ADDR_ALARM_SUMMARY);
    chk("pat_err", d, 8'h04);
    pattern_error_count = 8'h04;
    rd(ADDR_ALARM_SUMMARY);
    chk("pat_ok", d, 8'h00);
  endtask
  task automatic t_buffer;
    buffer_overflow = 1'h1;
    tick;
    buffer_overflow = 1'h0;
    repeat (10) tick;
    rd(ADDR_ALARM_SUMMARY);
    chk("buf_hold", d, 8'h08);
    buffer_reset = 1'h1;
    tick;
    buffer_reset = 1'h0;
    buffer_auto_recover = 1'h1;
    buffer_underflow = 1'h1;
    tick;
    buffer_underflow = 1'h0;
    rd(ADDR_ALARM_SUMMARY);
    chk("buf_under", d, 8'h08);
    repeat (10) tick;
    rd(ADDR_ALARM_SUMMARY);
    chk("buf_auto", d, 8'h00);
  endtask
  // hysteresis between assert limit 1 and release limit 8
  task automatic t_quality;
    wr(ADDR_ABSENT_CONTROL, 8'h08);
    quality_measure = 6'h01;
    wait_flag(1'h1);
    quality_measure = 6'h05;
    rd(ADDR_ALARM_SUMMARY);
    chk("q_hold", d, 8'h21);
    quality_measure = 6'h08;
    wait_flag(1'h0);
    quality_measure = 6'h00;
    repeat (3) tick;
    rd(ADDR_ABSENT_STATE);
    chk("q_state", d, 8'h11);
    pll_unlocked = 1'h1;
    repeat (3) tick;
    rd(ADDR_ABSENT_STATE);
    chk("q_lock", d, 8'h01);
    pll_unlocked = 1'h0;
    wr(ADDR_ABSENT_CONTROL, 8'h00);
    wait_flag(1'h0);
    quality_measure = 6'h3f;
  endtask
  // limit 0: 2048 equal bits set, one field with edges clears
  task automatic t_run(logic [1:0] m, logic b);
    logic det;
    det = m[1] | (m[0] & ~b);
    wr(ADDR_ABSENT_CONTROL, {5'h00, m, 1'h0});
    send(~b, 1, 1'h0);
    send(b, 2047, 1'h0);
    rd(ADDR_ABSENT_STATE);
    chk("run_early", d & 8'h04, 8'h00);
    send(b, 1, 1'h0);
    rd(ADDR_ABSENT_STATE);
    if (det)
      pol = b;
    chk("run_set", d & 8'h0c, {4'h0, pol, det, 2'h0});
    send(b, 2048, 1'h1);
    rd(ADDR_ABSENT_STATE);
    chk("run_clear", d & 8'h0c, {4'h0, pol, 3'h0});
  endtask
  // limit 1: 7168 equal bits set, 17 good fields clear
  task automatic t_limit;
    run_assert_limit = 8'h01;
    run_clear_limit = 8'h01;
    wr(ADDR_ABSENT_CONTROL, 8'h06);
    send(1'h0, 1, 1'h0);
    send(1'h1, 7167, 1'h0);
    rd(ADDR_ABSENT_STATE);
    chk("lim_early", d & 8'h0c, 8'h00);
    send(1'h1, 1, 1'h0);
    rd(ADDR_ABSENT_STATE);
    chk("lim_set", d & 8'h0c, 8'h0c);
    send(1'h1, 16384, 1'h1);
    rd(ADDR_ABSENT_STATE);
    chk("lim_hold", d & 8'h0c, 8'h0c);
    send(1'h1, 2048, 1'h1);
    rd(ADDR_ABSENT_STATE);
    chk("lim_clear", d & 8'h0c, 8'h08);
  endtask
  initial
  begin
    repeat (12) tick;
    sys_rst = 1'h0;
    t_reset;
    t_alarms;
    t_buffer;
    t_quality;
    t_run(2'h1, 1'h0);
    t_run(2'h1, 1'h1);
    t_run(2'h2, 1'h1);
    t_run(2'h3, 1'h0);
    t_run(2'h0, 1'h0);
    t_limit;
    results;
  end
endmodule
